// file: hw/bl_lock_fuse.sv
// boot lock protection and fuse high byte with AXI4-Lite access
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module bl_lock_fuse #(
    parameter int PROG_CYCLES = bl_pkg::PROG_CYCLES
) (
    // clock and power-on reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // AXI4-Lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // cpu side, same clock
    input  wire logic        core_reset,
    input  wire logic        spm_req,
    input  wire logic [1:0]  spm_kind,
    input  wire logic        spm_in_boot,
    input  wire logic [1:0]  spm_lock_data,
    input  wire logic        lpm_req,
    input  wire logic        lpm_in_boot,
    input  wire logic        pc_in_boot,
    input  wire logic        vectors_in_app,
    output logic             spm_busy,
    output logic             spm_done,
    output logic             spm_blocked,
    output logic             flash_write,
    output logic             flash_erase,
    output logic             lpm_grant,
    output logic             lpm_blocked,
    output logic             int_allow,
    // serial programming pin, asynchronous
    input  wire logic        serial_prog_pin,
    // configuration outputs
    output logic [7:0]       fuse_high_config,
    output logic             boot_lock_upper,
    output logic             boot_lock_lower,
    output logic             debug_on,
    output logic             test_port_on,
    output logic             serial_prog_on,
    output logic             oscillator_option_fuse,
    output logic             eeprom_keep,
    output logic [1:0]       boot_size,
    output logic             reset_vector_select
);
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        aw_have;
        logic [3:0]  aw_addr;
        logic        w_have;
        logic [7:0]  w_data;
        logic        w_lane0;
        logic [7:0]  fuse;
        logic [1:0]  lock;
        logic [2:0]  ser_sync;
        logic        ser_mode;
        logic [1:0]  spm_op;
        logic [1:0]  lock_data;
        logic        spm_done;
        logic        spm_blocked;
        logic        flash_write;
        logic        flash_erase;
        logic        lpm_grant;
        logic        lpm_blocked;
        logic        int_allow;
        logic        dbg_on;
        logic        test_on;
        logic        ser_on;
        logic        ee_keep;
    } bl_state_t;

    bl_state_t s_r;
    bl_state_t s_nxt;
    bl_if      bus ();

    // known register offset, shared by write and read paths
    function automatic logic bl_known(input logic [3:0] a);
        return (a == bl_pkg::OFS_FUSE) || (a == bl_pkg::OFS_LOCK) ||
               (a == bl_pkg::OFS_STAT);
    endfunction

    bl_lock_decode u_dec (
        .bus (bus.dec)
    );

    bl_prog_timer #(
        .CYCLES (PROG_CYCLES)
    ) u_tmr (
        .clock (clock),
        .nrst  (nrst),
        .bus   (bus.tmr)
    );

    assign bus.lock = s_r.lock;

    // a new operation starts only when idle and not refused
    assign bus.start = spm_req && !core_reset && !bus.busy &&
                       (!spm_in_boot || bus.spm_boot_ok);

    always_comb begin
        s_nxt             = s_r;
        s_nxt.spm_done    = bus.done;
        s_nxt.spm_blocked = 1'b0;
        s_nxt.lpm_grant   = 1'b0;
        s_nxt.lpm_blocked = 1'b0;

        // pin sync: stage 0 feeds stage 1 only, change taken once 1 and 2 agree
        s_nxt.ser_sync = {s_r.ser_sync[1:0], serial_prog_pin};
        if (s_r.ser_sync[1] == s_r.ser_sync[2]) begin
            s_nxt.ser_mode = s_r.ser_sync[2];
        end

        // bus write: address and data taken in either order
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_have  = 1'b1;
            s_nxt.w_data  = s_axi_wdata[7:0];
            s_nxt.w_lane0 = s_axi_wstrb[0];
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = bl_known(s_r.aw_addr) ? bl_pkg::RESP_OKAY : bl_pkg::RESP_SLVERR;
            if (s_r.w_lane0) begin
                case (s_r.aw_addr)
                    bl_pkg::OFS_FUSE: begin
                        s_nxt.fuse = s_r.w_data;
                        // serial enable frozen while the serial port programs
                        if (s_r.ser_mode) begin
                            s_nxt.fuse[bl_pkg::FB_SERIAL] = s_r.fuse[bl_pkg::FB_SERIAL];
                        end
                    end
                    bl_pkg::OFS_LOCK: begin
                        s_nxt.lock = s_r.w_data[1:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
        s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
        s_nxt.wready  = !s_nxt.w_have && !s_nxt.bvalid;

        // bus read: one cycle to the answer, raw bits so 0 means programmed
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = bl_known(s_axi_araddr) ? bl_pkg::RESP_OKAY : bl_pkg::RESP_SLVERR;
            s_nxt.rdata  = 32'h0;
            case (s_axi_araddr)
                bl_pkg::OFS_FUSE: s_nxt.rdata[7:0] = s_r.fuse;
                bl_pkg::OFS_LOCK: s_nxt.rdata[1:0] = s_r.lock;
                bl_pkg::OFS_STAT: begin
                    s_nxt.rdata[bl_pkg::SB_MODE +: 2] = bus.mode;
                    s_nxt.rdata[bl_pkg::SB_BUSY]      = bus.busy;
                    s_nxt.rdata[bl_pkg::SB_SER]       = s_r.ser_mode;
                    s_nxt.rdata[bl_pkg::SB_INTOK]     = s_r.int_allow;
                end
                default: begin
                end
            endcase
        end
        s_nxt.arready = !s_nxt.rvalid;

        // refused writes touch nothing: no strobe, no lock change
        if (spm_req && !core_reset && !bus.busy && !bus.start) begin
            s_nxt.spm_blocked = 1'b1;
        end
        if (bus.start) begin
            s_nxt.spm_op      = spm_kind;
            s_nxt.lock_data   = spm_lock_data;
            s_nxt.flash_write = (spm_kind == bl_pkg::SPM_WRITE);
            s_nxt.flash_erase = (spm_kind == bl_pkg::SPM_ERASE);
        end
        // strobes end with the timer, whatever the core reset does
        if (bus.done) begin
            s_nxt.flash_write = 1'b0;
            s_nxt.flash_erase = 1'b0;
            s_nxt.spm_op      = bl_pkg::SPM_NONE;
            // self-programmed lock write can only program bits
            if (s_r.spm_op == bl_pkg::SPM_LOCK) begin
                s_nxt.lock = s_nxt.lock & s_r.lock_data;
            end
        end

        // table read of boot from application code may be refused
        if (lpm_req && !core_reset) begin
            if (lpm_in_boot && !pc_in_boot && !bus.lpm_app_ok) begin
                s_nxt.lpm_blocked = 1'b1;
            end else begin
                s_nxt.lpm_grant = 1'b1;
            end
        end

        // interrupts held in modes 3 and 4 while inside boot with vectors in application
        s_nxt.int_allow = !(bus.int_guard && vectors_in_app && pc_in_boot);

        // decoded fuse enables, a 0 bit means the feature is on
        s_nxt.dbg_on  = !s_r.fuse[bl_pkg::FB_DEBUG];
        s_nxt.test_on = !s_r.fuse[bl_pkg::FB_TEST];
        s_nxt.ser_on  = !s_r.fuse[bl_pkg::FB_SERIAL];
        s_nxt.ee_keep = !s_r.fuse[bl_pkg::FB_EEKEEP];
    end

    // reset values follow the shipped fuse and lock settings
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_r           <= '0;
            s_r.awready   <= 1'b1;
            s_r.wready    <= 1'b1;
            s_r.arready   <= 1'b1;
            s_r.fuse      <= bl_pkg::FUSE_RST;
            s_r.lock      <= bl_pkg::LOCK_RST;
            s_r.spm_op    <= bl_pkg::SPM_NONE;
            s_r.int_allow <= 1'b1;
            s_r.dbg_on    <= !bl_pkg::FUSE_RST[bl_pkg::FB_DEBUG];
            s_r.test_on   <= !bl_pkg::FUSE_RST[bl_pkg::FB_TEST];
            s_r.ser_on    <= !bl_pkg::FUSE_RST[bl_pkg::FB_SERIAL];
            s_r.ee_keep   <= !bl_pkg::FUSE_RST[bl_pkg::FB_EEKEEP];
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign s_axi_awready          = s_r.awready;
    assign s_axi_wready           = s_r.wready;
    assign s_axi_bvalid           = s_r.bvalid;
    assign s_axi_bresp            = s_r.bresp;
    assign s_axi_arready          = s_r.arready;
    assign s_axi_rvalid           = s_r.rvalid;
    assign s_axi_rdata            = s_r.rdata;
    assign s_axi_rresp            = s_r.rresp;
    assign spm_busy               = bus.busy;
    assign spm_done               = s_r.spm_done;
    assign spm_blocked            = s_r.spm_blocked;
    assign flash_write            = s_r.flash_write;
    assign flash_erase            = s_r.flash_erase;
    assign lpm_grant              = s_r.lpm_grant;
    assign lpm_blocked            = s_r.lpm_blocked;
    assign int_allow              = s_r.int_allow;
    assign fuse_high_config       = s_r.fuse;
    assign boot_lock_upper        = s_r.lock[bl_pkg::LB_UPPER];
    assign boot_lock_lower        = s_r.lock[bl_pkg::LB_LOWER];
    assign debug_on               = s_r.dbg_on;
    assign test_port_on           = s_r.test_on;
    assign serial_prog_on         = s_r.ser_on;
    assign oscillator_option_fuse = s_r.fuse[bl_pkg::FB_OSC];
    assign eeprom_keep            = s_r.ee_keep;
    assign boot_size              = s_r.fuse[bl_pkg::FB_BSZ_HI:bl_pkg::FB_BSZ_LO];
    assign reset_vector_select    = s_r.fuse[bl_pkg::FB_RSTVEC];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    logic spm_try;
    assign spm_try = spm_req && !core_reset && !bus.busy;

    property p_mode1_free;
        spm_try && (s_r.lock == 2'h3) |=> !spm_blocked && spm_busy;
    endproperty
    a_mode1_free: assert property (p_mode1_free) else $error("mode 1 write refused");

    property p_mode2_block;
        spm_try && spm_in_boot && (s_r.lock == 2'h2) |=> spm_blocked && !spm_busy;
    endproperty
    a_mode2_block: assert property (p_mode2_block) else $error("mode 2 write let through");

    property p_mode3_read;
        lpm_req && !core_reset && lpm_in_boot && !pc_in_boot && (s_r.lock == 2'h0)
        |=> lpm_blocked && !lpm_grant;
    endproperty
    a_mode3_read: assert property (p_mode3_read) else $error("mode 3 read let through");

    property p_mode4_write;
        spm_try && spm_in_boot && (s_r.lock == 2'h1) |=> spm_busy && !spm_blocked;
    endproperty
    a_mode4_write: assert property (p_mode4_write) else $error("mode 4 write refused");

    property p_int_hold;
        !s_r.lock[bl_pkg::LB_UPPER] && vectors_in_app && pc_in_boot |=> !int_allow;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("interrupts not held");

    property p_fuse_read;
        s_axi_arvalid && s_axi_arready && (s_axi_araddr == bl_pkg::OFS_FUSE)
        |=> s_axi_rvalid && (s_axi_rdata[7:0] == $past(s_r.fuse));
    endproperty
    a_fuse_read: assert property (p_fuse_read) else $error("fuse read wrong");

    property p_debug_on;
        !s_r.fuse[bl_pkg::FB_DEBUG] ##1 !s_r.fuse[bl_pkg::FB_DEBUG] |-> debug_on;
    endproperty
    a_debug_on: assert property (p_debug_on) else $error("debug not enabled");

    property p_serial_frozen;
        s_r.ser_mode && s_r.aw_have && s_r.w_have && !s_r.bvalid
        |=> s_r.fuse[bl_pkg::FB_SERIAL] == $past(s_r.fuse[bl_pkg::FB_SERIAL]);
    endproperty
    a_serial_frozen: assert property (p_serial_frozen) else $error("serial fuse changed");

    property p_block_quiet;
        spm_blocked |-> !flash_write && !flash_erase && $stable(s_r.lock);
    endproperty
    a_block_quiet: assert property (p_block_quiet) else $error("refused write acted");
endmodule // bl_lock_fuse

// file: hw/bl_pkg.sv
// constants and types shared by the boot lock and fuse configuration block
package bl_pkg;

    // register byte offsets on the bus
    localparam logic [3:0] OFS_FUSE = 4'h0;
    localparam logic [3:0] OFS_LOCK = 4'h4;
    localparam logic [3:0] OFS_STAT = 4'h8;

    // fuse high byte field positions
    localparam int FB_DEBUG  = 7;
    localparam int FB_TEST   = 6;
    localparam int FB_SERIAL = 5;
    localparam int FB_OSC    = 4;
    localparam int FB_EEKEEP = 3;
    localparam int FB_BSZ_HI = 2;
    localparam int FB_BSZ_LO = 1;
    localparam int FB_RSTVEC = 0;

    // lock register field positions
    localparam int LB_UPPER = 1;
    localparam int LB_LOWER = 0;

    // status register field positions
    localparam int SB_MODE  = 0;
    localparam int SB_BUSY  = 2;
    localparam int SB_SER   = 3;
    localparam int SB_INTOK = 4;

    // values after reset; a 0 bit means programmed
    localparam logic [7:0] FUSE_RST = 8'h99;
    localparam logic [1:0] LOCK_RST = 2'h3;

    // self-programming time from the calibrated oscillator
    localparam int CLK_NS      = 20;
    localparam int PROG_MIN_NS = 3700000;
    localparam int PROG_MAX_NS = 4500000;
    localparam int PROG_CYCLES = (PROG_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROG_MAX_CY = PROG_MAX_NS / CLK_NS;

    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // boot lock protection modes, mode 1 first
    typedef enum logic [1:0] {BL_MODE1, BL_MODE2, BL_MODE3, BL_MODE4} bl_mode_t;

    // self-programming operations
    typedef enum logic [1:0] {SPM_ERASE, SPM_WRITE, SPM_LOCK, SPM_NONE} bl_spm_t;

endpackage

// file: hw/bl_if.sv
// carrier between the top, the lock decoder and the programming timer
`timescale 1ns/1ps
interface bl_if;
    logic [1:0]     lock;
    bl_pkg::bl_mode_t mode;
    logic           spm_boot_ok;
    logic           lpm_app_ok;
    logic           int_guard;
    logic           start;
    logic           busy;
    logic           done;

    modport top (output lock, output start, input mode, input spm_boot_ok,
                 input lpm_app_ok, input int_guard, input busy, input done);
    modport dec (input lock, output mode, output spm_boot_ok, output lpm_app_ok,
                 output int_guard);
    modport tmr (input start, output busy, output done);
endinterface

// file: hw/bl_lock_decode.sv
// decode of the two boot lock bits into protection permissions
`timescale 1ns/1ps
module bl_lock_decode (
    // lock bits in, permissions out
    bl_if.dec bus
);
    // upper and lower bit, 1 = unprogrammed
    always_comb begin
        case (bus.lock)
            2'h3:    bus.mode = bl_pkg::BL_MODE1;
            2'h2:    bus.mode = bl_pkg::BL_MODE2;
            2'h0:    bus.mode = bl_pkg::BL_MODE3;
            default: bus.mode = bl_pkg::BL_MODE4;
        endcase
    end

    // writes into boot allowed in modes 1 and 4 only
    assign bus.spm_boot_ok = (bus.mode == bl_pkg::BL_MODE1) ||
                             (bus.mode == bl_pkg::BL_MODE4);
    // reads of boot from application code allowed in modes 1 and 2
    assign bus.lpm_app_ok  = (bus.mode == bl_pkg::BL_MODE1) ||
                             (bus.mode == bl_pkg::BL_MODE2);
    // modes 3 and 4 guard interrupts while running in boot
    assign bus.int_guard   = (bus.mode == bl_pkg::BL_MODE3) ||
                             (bus.mode == bl_pkg::BL_MODE4);
endmodule // bl_lock_decode

// file: hw/bl_prog_timer.sv
// fixed-length timer for self-programmed erase, write and lock writes
`timescale 1ns/1ps
module bl_prog_timer #(
    parameter int CYCLES = bl_pkg::PROG_CYCLES
) (
    // clock and power-on reset only
    input  wire logic clock,
    input  wire logic nrst,
    // start in, busy and done out
    bl_if.tmr         bus
);
    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic          busy;
        logic          done;
    } bl_tmr_t;

    bl_tmr_t s_r;
    bl_tmr_t s_nxt;
    logic [CW-1:0] len_r;

    // core reset is not wired in, so a running write always completes
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        if (s_r.busy) begin
            if (s_r.count == '0) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
            end else begin
                s_nxt.count = s_r.count - CW'(1);
            end
        end else if (bus.start) begin
            s_nxt.busy  = 1'b1;
            s_nxt.count = CW'(CYCLES - 1);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus.busy = s_r.busy;
    assign bus.done = s_r.done;

    // helper: length of the current busy stretch
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            len_r <= '0;
        end else begin
            len_r <= s_r.busy ? len_r + CW'(1) : '0;
        end
    end

    property p_prog_len;
        @(posedge clock) disable iff (!nrst)
        $fell(s_r.busy) |-> s_r.done && ($past(len_r) == CW'(CYCLES - 1));
    endproperty
    a_prog_len: assert property (p_prog_len) else $error("program time wrong");

    property p_prog_carry;
        @(posedge clock) disable iff (!nrst)
        s_r.busy && (s_r.count != '0) |=> s_r.busy;
    endproperty
    a_prog_carry: assert property (p_prog_carry) else $error("write cut short");
endmodule // bl_prog_timer

// file: testbench/bl_cpu_model.sv
// cpu core model raising self-programming and table-read requests
`timescale 1ns/1ps
module bl_cpu_model (
    // clock
    input  wire logic clock,
    // requests toward the block
    output logic       core_reset,
    output logic       spm_req,
    output logic [1:0] spm_kind,
    output logic       spm_in_boot,
    output logic [1:0] spm_lock_data,
    output logic       lpm_req,
    output logic       lpm_in_boot,
    // where the core executes
    output logic       pc_in_boot,
    output logic       vectors_in_app
);
    // idle levels from time zero
    initial begin
        {core_reset, spm_req, spm_kind, spm_in_boot, lpm_req, lpm_in_boot} = '0;
        {pc_in_boot, vectors_in_app} = '0;
        spm_lock_data = 2'h3;
    end
    // qualifiers held up to the taking edge
    task automatic spm(input logic [1:0] k, input logic b, input logic [1:0] ld);
        @(posedge clock);
        spm_kind      <= k;
        spm_in_boot   <= b;
        spm_lock_data <= ld;
        spm_req       <= 1'b1;
        @(posedge clock);
        spm_req       <= 1'b0;
    endtask
    // one-cycle table read
    task automatic program_table_read(input logic b);
        @(posedge clock);
        lpm_in_boot <= b;
        lpm_req     <= 1'b1;
        @(posedge clock);
        lpm_req     <= 1'b0;
    endtask
endmodule // bl_cpu_model

// file: testbench/tb_top.sv
// self-checking bench for the boot lock and fuse block
`timescale 1ns/1ps
module tb_top;
    localparam int PROG = 20;
    logic clock = 1'b0, nrst = 1'b0, serial_prog_pin = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, spm_kind, spm_lock_data, boot_size, r;
    logic core_reset, spm_req, spm_in_boot, lpm_req, lpm_in_boot, pc_in_boot, vectors_in_app;
    logic spm_busy, spm_done, spm_blocked, flash_write, flash_erase, lpm_grant, lpm_blocked;
    logic int_allow, boot_lock_upper, boot_lock_lower, debug_on, test_port_on, serial_prog_on;
    logic oscillator_option_fuse, eeprom_keep, reset_vector_select;
    logic [7:0] fuse_high_config;
    int fail_count = 0, n_compared = 0;

    bl_lock_fuse #(.PROG_CYCLES(PROG)) u_dut (.clock, .nrst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_reset, .spm_req,
        .spm_kind, .spm_in_boot, .spm_lock_data, .lpm_req, .lpm_in_boot, .pc_in_boot,
        .vectors_in_app, .spm_busy, .spm_done, .spm_blocked, .flash_write, .flash_erase,
        .lpm_grant, .lpm_blocked, .int_allow, .serial_prog_pin, .fuse_high_config,
        .boot_lock_upper, .boot_lock_lower, .debug_on, .test_port_on, .serial_prog_on,
        .oscillator_option_fuse, .eeprom_keep, .boot_size, .reset_vector_select);
    bl_cpu_model u_cpu (.clock, .core_reset, .spm_req, .spm_kind, .spm_in_boot,
        .spm_lock_data, .lpm_req, .lpm_in_boot, .pc_in_boot, .vectors_in_app);

    // 50 MHz
    always #10 clock = ~clock;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // a used-up bound counts as a failure and ends the run
    task automatic wait_ok(input int n);
        if (n >= 100) begin
            fail_count++;
            $display("timeout waiting for the block");
            close_out;
        end
    endtask
    // write: address and data offered together, bready held until bvalid
    task automatic axw(input logic [3:0] a, input logic [31:0] v);
        int n;
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        wait_ok(n);
    endtask
    task automatic axr(input logic [3:0] a);
        int n;
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        wait_ok(n);
    endtask
    // shipped fuse byte and decoded enables
    task automatic t_reset;
        axr(4'h0);
        chk("fuse", d, 32'h99);
        axr(4'h4);
        chk("lock", d, 32'h3);
        chk("cfg", {fuse_high_config, boot_lock_upper, boot_lock_lower}, 10'h267);
        chk("enables", {debug_on, test_port_on, serial_prog_on, eeprom_keep}, 4'h6);
        chk("raw", {oscillator_option_fuse, boot_size, reset_vector_select}, 4'h9);
        $display("test reset finished");
    endtask
    // fuses always written before any lock write
    task automatic t_fuse;
        axw(4'h0, 32'h77);
        chk("wresp", r, 2'h0);
        axr(4'h0);
        chk("fuse", d, 32'h77);
        chk("enables", {debug_on, test_port_on, serial_prog_on, eeprom_keep}, 4'h9);
        chk("raw", {oscillator_option_fuse, boot_size, reset_vector_select}, 4'hF);
        axw(4'h0, 32'h99);
        $display("test fuse finished");
    endtask
    // serial enable bit frozen while serial programming runs
    task automatic t_serial;
        serial_prog_pin <= 1'b1;
        repeat (4) @(posedge clock);
        axw(4'h0, 32'hFF);
        axr(4'h0);
        chk("fuse", d, 32'hDF);
        serial_prog_pin <= 1'b0;
        repeat (4) @(posedge clock);
        axw(4'h0, 32'h99);
        $display("test serial finished");
    endtask
    // every lock mode: boot write, boot read from application, interrupt guard
    task automatic t_modes;
        logic [1:0] lk [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
        int n;
        for (int m = 0; m < 4; m++) begin
            axw(4'h4, {30'h0, lk[m]});
            axr(4'h8);
            chk("mode", d[1:0], m[1:0]);
            u_cpu.spm(2'h1, 1'b1, 2'h3);
            @(posedge clock);
            chk("spm_blocked", spm_blocked, m == 1 || m == 2);
            chk("flash_write", flash_write, m == 0 || m == 3);
            chk("flash_erase", flash_erase, 1'b0);
            for (n = 0; n < 100 && !spm_blocked; n++) begin
                @(posedge clock);
                if (spm_done) break;
            end
            wait_ok(n);
            u_cpu.program_table_read(1'b1);
            @(posedge clock);
            chk("lpm_blocked", lpm_blocked, m >= 2);
            chk("lpm_grant", lpm_grant, m < 2);
            u_cpu.pc_in_boot <= 1'b1;
            u_cpu.vectors_in_app <= 1'b1;
            repeat (3) @(posedge clock);
            chk("int_allow", int_allow, m < 2);
            u_cpu.pc_in_boot <= 1'b0;
        end
        axw(4'h4, 32'h3);
        $display("test modes finished");
    endtask
    // lock write through self-programming, core reset pulsed mid-operation
    task automatic t_prog;
        int n;
        int c = 0;
        u_cpu.spm(2'h2, 1'b0, 2'h2);
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (spm_busy) c++;
            u_cpu.core_reset <= (c == 5);
            if (spm_done) break;
        end
        wait_ok(n);
        chk("busy_cycles", c, PROG);
        axr(4'h4);
        chk("lock", d, 32'h2);
        $display("test prog finished");
    endtask
    task automatic t_unmapped;
        axr(4'hC);
        chk("rresp", r, 2'h2);
        chk("rdata", d, 32'h0);
        axw(4'hC, 32'h0);
        chk("bresp", r, 2'h2);
        $display("test unmapped finished");
    endtask

    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        t_reset;
        t_fuse;
        t_serial;
        t_modes;
        t_prog;
        t_unmapped;
        close_out;
    end
endmodule // tb_top
